/* pkg/atone_pkg.sv */
// alarm tone output: register map, field positions, reset values and divisor taps
package atone_pkg;

	// register indices; byte address is four times the index
	localparam logic [11:0] PFS_IDX = 12'h004; // port_function_select
	localparam logic [11:0] TSC_IDX = 12'h025; // tone_and_serial_control
	localparam logic [11:0] PIO_IDX = 12'h040; // general_io_bit3 data and direction
	localparam logic [11:0] STAT_IDX = 12'h041; // block status, read only
	localparam int unsigned APB_ADDR_W = 12;

	// reset values
	localparam logic [3:0] PFS_RST = 4'h0;
	localparam logic [3:0] TSC_RST = 4'h0;
	localparam logic PIO_DATA_RST = 1'b0;
	localparam logic PIO_DIR_RST = 1'b0;

	// field positions
	localparam int unsigned PFS_PIN_SEL_BIT = 3; // alarm_pin_select
	localparam int unsigned TSC_FREQ_HI_BIT = 3; // alarm_freq_sel_hi
	localparam int unsigned TSC_FREQ_LO_BIT = 2; // alarm_freq_sel_lo
	localparam int unsigned PIO_DATA_BIT = 0;
	localparam int unsigned PIO_DIR_BIT = 1;
	localparam int unsigned STAT_PIN_SEL_BIT = 0;
	localparam int unsigned STAT_FREQ_LO_BIT = 1; // bits 2:1 hold the active divisor
	localparam int unsigned STAT_TONE_BIT = 3;
	localparam int unsigned STAT_PIN_IN_BIT = 4;
	localparam int unsigned STAT_STOP_BIT = 5;

	// peripheral prescaler width: enough for the slowest divisor of 2048
	localparam int unsigned PRESC_W = 11;

	// alarm divisor selection
	typedef enum logic [1:0] {
		ATONE_DIV2048 = 2'b00,
		ATONE_DIV1024 = 2'b01,
		ATONE_DIV512 = 2'b10,
		ATONE_DIV256 = 2'b11
	} atone_freq_e;

	// low prescaler bits that are all ones in the last cycle of a half period
	localparam logic [10:0] HALF_MASK_2048 = 11'h3ff;
	localparam logic [10:0] HALF_MASK_1024 = 11'h1ff;
	localparam logic [10:0] HALF_MASK_512 = 11'h0ff;
	localparam logic [10:0] HALF_MASK_256 = 11'h07f;

	// tap mask for a divisor selection
	function automatic logic [10:0] atone_half_mask(input atone_freq_e sel);
		logic [10:0] m;
		m = HALF_MASK_2048;
		unique case (sel)
			ATONE_DIV2048: m = HALF_MASK_2048;
			ATONE_DIV1024: m = HALF_MASK_1024;
			ATONE_DIV512: m = HALF_MASK_512;
			ATONE_DIV256: m = HALF_MASK_256;
		endcase
		return m;
	endfunction

endpackage

/* core/atone_presc.sv */
// peripheral prescaler: free-running binary divider of the peripheral clock
`timescale 1ns/1ps
`default_nettype none
module atone_presc #(
	parameter int unsigned W = 11
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_en,
	input wire logic i_clear,
	output logic [W-1:0] o_count
);

	typedef struct packed {
		logic [W-1:0] count;
	} atone_presc_s;

	atone_presc_s s_q;
	atone_presc_s s_d;

	// the slowest divisor needs eleven stages
	if (W < 11) begin : g_bad_width
		$error("atone_presc: W must be at least 11");
	end

	// count up, or hold at zero while cleared
	always_comb begin
		s_d = s_q;
		if (i_clear) begin
			s_d.count = '0;
		end else begin
			s_d.count = s_q.count + {{(W-1){1'b0}}, 1'b1};
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			s_q <= '0;
		end else if (i_en) begin
			s_q <= s_d;
		end
	end

	assign o_count = s_q.count;

endmodule // atone_presc
`default_nettype wire

/* core/atone_sync.sv */
// two-stage synchroniser for a level arriving from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module atone_sync #(
	parameter int unsigned WIDTH = 1
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_en,
	input wire logic [WIDTH-1:0] i_d,
	output logic [WIDTH-1:0] o_q
);

	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] sync;
	} atone_sync_s;

	atone_sync_s s_q;
	atone_sync_s s_d;

	if (WIDTH < 1) begin : g_bad_width
		$error("atone_sync: WIDTH must be at least 1");
	end

	// first stage feeds only the second stage
	always_comb begin
		s_d.meta = i_d;
		s_d.sync = s_q.meta;
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			s_q <= '0;
		end else if (i_en) begin
			s_q <= s_d;
		end
	end

	assign o_q = s_q.sync;

endmodule // atone_sync
`default_nettype wire

/* core/atone_top.sv */
// alarm tone output block: apb registers, tone divider and shared pin control
//
// Summary of operation
// - with alarm_pin_select set the shared pin carries the tone, with it clear (reset) it is general_io_bit3.
// - the frequency field divides the peripheral clock by 2048, 1024, 512 or 256 for codes 00 to 11.
// - every tone frequency is taken from taps of the peripheral prescaler, no other oscillator.
// - the tone is a square wave with equal high and low halves.
// - both frequency bits return to zero on reset and whenever stop mode is active.
// - port_function_select is four bits, write only, resets to zero, pin select in bit 3.
// - tone_and_serial_control is four bits, write only, resets to zero, frequency in bits 3:2.
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module atone_top #(
	parameter int unsigned ADDR_W = atone_pkg::APB_ADDR_W
) (
	input wire logic I_CORE_CLK,
	input wire logic I_RST,
	input wire logic I_CLK_EN,
	input wire logic I_STOP_MODE,
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_PWRITE,
	input wire logic [ADDR_W-1:0] I_PADDR,
	input wire logic [31:0] I_PWDATA,
	input wire logic [3:0] I_PSTRB,
	output logic O_PREADY,
	output logic [31:0] O_PRDATA,
	output logic O_PSLVERR,
	input wire logic I_PIN_IN,
	output logic O_PIN_OUT,
	output logic O_PIN_OE
);

	// the decoder compares full byte addresses up to the highest index
	if (ADDR_W < 12) begin : g_bad_addr_w
		$error("atone_top: ADDR_W must be at least 12");
	end

	// all state of the block apart from the prescaler count and the pin synchroniser stages
	typedef struct packed {
		logic [3:0] pfs;
		logic [3:0] tsc;
		logic pio_data;
		logic pio_dir;
		atone_pkg::atone_freq_e freq_act;
		logic tone;
		logic pin_out;
		logic pin_oe;
		logic pready;
		logic [31:0] prdata;
		logic pslverr;
	} atone_state_s;

	localparam atone_state_s ST_RST = '{
		pfs: atone_pkg::PFS_RST,
		tsc: atone_pkg::TSC_RST,
		pio_data: atone_pkg::PIO_DATA_RST,
		pio_dir: atone_pkg::PIO_DIR_RST,
		freq_act: atone_pkg::ATONE_DIV2048,
		tone: 1'b0,
		pin_out: 1'b0,
		pin_oe: 1'b0,
		pready: 1'b0,
		prdata: 32'h0000_0000,
		pslverr: 1'b0
	};

	atone_state_s s_q;
	atone_state_s s_d;

	logic [atone_pkg::PRESC_W-1:0] presc_count;
	logic pin_in_sync;

	// one-hot register decode, used by both the read and the write path
	function automatic logic [3:0] atone_decode(input logic [ADDR_W-1:0] addr);
		logic [3:0] hit;
		hit = 4'h0;
		if (addr[1:0] == 2'b00 && addr[ADDR_W-1:2] == (ADDR_W-2)'(atone_pkg::PFS_IDX)) begin
			hit[0] = 1'b1;
		end
		if (addr[1:0] == 2'b00 && addr[ADDR_W-1:2] == (ADDR_W-2)'(atone_pkg::TSC_IDX)) begin
			hit[1] = 1'b1;
		end
		if (addr[1:0] == 2'b00 && addr[ADDR_W-1:2] == (ADDR_W-2)'(atone_pkg::PIO_IDX)) begin
			hit[2] = 1'b1;
		end
		if (addr[1:0] == 2'b00 && addr[ADDR_W-1:2] == (ADDR_W-2)'(atone_pkg::STAT_IDX)) begin
			hit[3] = 1'b1;
		end
		return hit;
	endfunction

	// peripheral prescaler, held at zero in stop mode
	atone_presc #(
		.W(atone_pkg::PRESC_W)
	) u_presc (
		.i_clk(I_CORE_CLK),
		.i_rst(I_RST),
		.i_en(I_CLK_EN),
		.i_clear(I_STOP_MODE),
		.o_count(presc_count)
	);

	// the pad level comes from outside the clock domain
	atone_sync #(
		.WIDTH(1)
	) u_pin_sync (
		.i_clk(I_CORE_CLK),
		.i_rst(I_RST),
		.i_en(I_CLK_EN),
		.i_d(I_PIN_IN),
		.o_q(pin_in_sync)
	);

	// next-state logic: bus slave, registers, tone and pin
	always_comb begin
		logic [3:0] hit;
		logic commit;
		logic [10:0] mask;
		logic boundary;
		logic [31:0] rdata;
		hit = 4'h0;
		commit = 1'b0;
		mask = 11'h000;
		boundary = 1'b0;
		rdata = 32'h0000_0000;
		s_d = s_q;

		hit = atone_decode(I_PADDR);

		// read mux; the two mode registers are write only and read zero
		rdata[atone_pkg::PIO_DATA_BIT] = hit[2] & s_q.pio_data;
		rdata[atone_pkg::PIO_DIR_BIT] = hit[2] & s_q.pio_dir;
		if (hit[3]) begin
			rdata[atone_pkg::STAT_PIN_SEL_BIT] = s_q.pfs[atone_pkg::PFS_PIN_SEL_BIT];
			rdata[atone_pkg::STAT_FREQ_LO_BIT +: 2] = s_q.freq_act;
			rdata[atone_pkg::STAT_TONE_BIT] = s_q.tone;
			rdata[atone_pkg::STAT_PIN_IN_BIT] = pin_in_sync;
			rdata[atone_pkg::STAT_STOP_BIT] = I_STOP_MODE;
		end

		// one wait state: ready rises in the second access cycle
		s_d.pready = 1'b0;
		s_d.pslverr = 1'b0;
		if (I_PSEL && I_PENABLE && !s_q.pready) begin
			s_d.pready = 1'b1;
			s_d.pslverr = ~|hit;
			s_d.prdata = I_PWRITE ? 32'h0000_0000 : rdata;
		end

		// a write takes effect on the edge where ready is sampled high
		commit = I_PSEL & I_PENABLE & s_q.pready & I_PWRITE & I_PSTRB[0];
		if (commit && hit[0]) begin
			s_d.pfs = I_PWDATA[3:0];
		end
		if (commit && hit[1]) begin
			s_d.tsc = I_PWDATA[3:0];
		end
		if (commit && hit[2]) begin
			s_d.pio_data = I_PWDATA[atone_pkg::PIO_DATA_BIT];
			s_d.pio_dir = I_PWDATA[atone_pkg::PIO_DIR_BIT];
		end

		// half-period boundary of the divisor now in use
		mask = atone_pkg::atone_half_mask(s_q.freq_act);
		boundary = (presc_count & mask) == mask;
		if (boundary) begin
			s_d.tone = ~s_q.tone;
			s_d.freq_act = atone_pkg::atone_freq_e'(
				s_q.tsc[atone_pkg::TSC_FREQ_HI_BIT:atone_pkg::TSC_FREQ_LO_BIT]);
		end

		// stop mode clears the frequency bits, wins over a write
		if (I_STOP_MODE) begin
			s_d.tsc[atone_pkg::TSC_FREQ_HI_BIT] = 1'b0;
			s_d.tsc[atone_pkg::TSC_FREQ_LO_BIT] = 1'b0;
			s_d.freq_act = atone_pkg::ATONE_DIV2048;
			s_d.tone = 1'b0;
		end

		// shared pin: tone driver, or general_io_bit3 with its own direction
		if (s_d.pfs[atone_pkg::PFS_PIN_SEL_BIT]) begin
			s_d.pin_out = s_d.tone;
			s_d.pin_oe = 1'b1;
		end else begin
			s_d.pin_out = s_d.pio_data;
			s_d.pin_oe = s_d.pio_dir;
		end
	end

	// state register; reset clears the frequency bits
	always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
		if (I_RST) begin
			s_q <= ST_RST;
		end else if (I_CLK_EN) begin
			s_q <= s_d;
		end
	end

	// outputs straight from the state register
	assign O_PREADY = s_q.pready;
	assign O_PRDATA = s_q.prdata;
	assign O_PSLVERR = s_q.pslverr;
	assign O_PIN_OUT = s_q.pin_out;
	assign O_PIN_OE = s_q.pin_oe;

endmodule // atone_top
`default_nettype wire

/* tb/atone_properties.sv */
// checker: bus timing, pin and tone period relations at the block ports
`timescale 1ns/1ps
`default_nettype none
module atone_properties #(
	parameter int unsigned ADDR_W = 12
) (
	input wire logic I_CORE_CLK,
	input wire logic I_RST,
	input wire logic I_CLK_EN,
	input wire logic I_STOP_MODE,
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_PWRITE,
	input wire logic [ADDR_W-1:0] I_PADDR,
	input wire logic O_PREADY,
	input wire logic [31:0] O_PRDATA,
	input wire logic O_PSLVERR,
	input wire logic O_PIN_OUT,
	input wire logic O_PIN_OE
);
	default clocking cb @(posedge I_CORE_CLK); endclocking
	default disable iff (I_RST);
	logic [11:0] run_q;
	logic clean_q;
	logic pfx_wr;
	// writes other than the frequency register may move the pin themselves
	assign pfx_wr = I_PSEL && I_PWRITE && (I_PADDR != ADDR_W'(atone_pkg::TSC_IDX * 4));
	// cycles since the pin last moved, and whether that move was a tone edge
	always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
		if (I_RST) begin
			run_q <= 12'h000;
			clean_q <= 1'b0;
		end else if (pfx_wr || I_STOP_MODE) begin
			clean_q <= 1'b0;
		end else if ($changed(O_PIN_OUT)) begin
			run_q <= 12'h001;
			clean_q <= !$past(pfx_wr) && !$past(I_STOP_MODE);
		end else if (I_CLK_EN) begin
			run_q <= run_q + 12'h001;
		end
	end
	sequence s_setup;
		I_PSEL && !I_PENABLE;
	endsequence
	sequence s_wait;
		I_PSEL && I_PENABLE && !O_PREADY && I_CLK_EN;
	endsequence
	chk_ready_wait: assert property (s_setup ##1 s_wait |=> O_PREADY)
		else $error("ready late");
	chk_ready_pulse: assert property (O_PREADY |=> !O_PREADY)
		else $error("ready too long");
	chk_ready_cause: assert property (O_PREADY |-> $past(I_PSEL) && $past(I_PENABLE))
		else $error("ready outside access");
	chk_err_ready: assert property (O_PSLVERR |-> O_PREADY)
		else $error("error without ready");
	chk_rdata_hold: assert property (!O_PREADY |-> $stable(O_PRDATA))
		else $error("read data moved");
	chk_oe_cause: assert property ($changed(O_PIN_OE) |-> $past(I_PSEL))
		else $error("enable moved alone");
	chk_clken_hold: assert property (!I_CLK_EN |=> $stable(O_PIN_OUT) && $stable(O_PREADY))
		else $error("moved while frozen");
	chk_reset_quiet: assert property ($fell(I_RST) |-> !O_PIN_OE && !O_PREADY && !O_PIN_OUT)
		else $error("outputs busy after reset");
	chk_tone_half: assert property ($changed(O_PIN_OUT) && clean_q && !$past(pfx_wr) &&
		!$past(I_STOP_MODE) |-> run_q inside {12'h080, 12'h100, 12'h200, 12'h400})
		else $error("tone half period wrong");
	// the entry edge may still drop the tone once, so stop must have stood two cycles
	chk_stop_still: assert property (I_STOP_MODE && $past(I_STOP_MODE) &&
		$past(I_STOP_MODE, 2) && !$past(pfx_wr) |->
		$stable(O_PIN_OUT)) else $error("pin moved in stop");
endmodule // atone_properties
bind atone_top atone_properties #(.ADDR_W(ADDR_W)) u_props (.I_CORE_CLK, .I_RST, .I_CLK_EN,
	.I_STOP_MODE, .I_PSEL, .I_PENABLE, .I_PWRITE, .I_PADDR, .O_PREADY, .O_PRDATA, .O_PSLVERR,
	.O_PIN_OUT, .O_PIN_OE);
`default_nettype wire

/* tb/atone_buzzer_model.sv */
// buzzer on the shared pin: resolves the pad and measures high and low times
`timescale 1ns/1ps
`default_nettype none
module atone_buzzer_model (
	input wire logic i_clk,
	input wire logic i_oe,
	input wire logic i_out,
	input wire logic i_ext_en,
	input wire logic i_ext,
	output logic o_pad,
	output logic [11:0] o_hi,
	output logic [11:0] o_lo
);
	logic last_q = 1'b0;
	logic drv_q = 1'b0;
	logic [11:0] cnt_q = 12'h001;
	// an undriven pad shows i_ext when i_ext_en is set, else the inverse of the last driven level
	assign o_pad = i_oe ? i_out : (i_ext_en ? i_ext : ~drv_q);
	// length of the latest high and low intervals, in core cycles
	always @(posedge i_clk) begin
		if (i_oe) drv_q <= i_out;
		if (o_pad != last_q) begin
			if (last_q) o_hi <= cnt_q;
			else o_lo <= cnt_q;
			cnt_q <= 12'h001;
		end else cnt_q <= cnt_q + 12'h001;
		last_q <= o_pad;
	end
endmodule // atone_buzzer_model
`default_nettype wire

/* tb/alarm_tone_output_tb_top.sv */
// testbench: register access, tone periods, stop, reset and shared pin
`timescale 1ns/1ps
`default_nettype none
module alarm_tone_output_tb_top;
	localparam logic [11:0] A_PFS = 12'(atone_pkg::PFS_IDX * 4);
	localparam logic [11:0] A_TSC = 12'(atone_pkg::TSC_IDX * 4);
	localparam logic [11:0] A_PIO = 12'(atone_pkg::PIO_IDX * 4);
	localparam logic [11:0] A_ST = 12'(atone_pkg::STAT_IDX * 4);
	logic clk = 1'b0, rst = 1'b1, en = 1'b1, stop = 1'b0, xen = 1'b0, xv = 1'b0;
	logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, e;
	logic [11:0] pa = 12'h000, hi, lo;
	logic [31:0] pwd = 32'h0, prd, rd;
	logic rdy, err, pout, poe, pad;
	int error_cnt = 0;
	int checks = 0;
	// core clock, 4 ns period
	always #2 clk = ~clk;
	atone_top dut (.I_CORE_CLK(clk), .I_RST(rst), .I_CLK_EN(en), .I_STOP_MODE(stop),
		.I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(pa), .I_PWDATA(pwd),
		.I_PSTRB(4'hf), .O_PREADY(rdy), .O_PRDATA(prd), .O_PSLVERR(err), .I_PIN_IN(pad),
		.O_PIN_OUT(pout), .O_PIN_OE(poe));
	atone_buzzer_model bz (.i_clk(clk), .i_oe(poe), .i_out(pout), .i_ext_en(xen),
		.i_ext(xv), .o_pad(pad), .o_hi(hi), .o_lo(lo));
	task automatic close_out;
		$display("checks=%0d errors=%0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic cmp(input logic [31:0] g, input logic [31:0] x);
		checks++;
		if (g !== x) begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask
	// one transfer; read data and error are taken at the ready edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		pa <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (rdy !== 1'b1 && n < 20);
		if (n >= 20) cmp(32'(rdy), 32'h1);
		rd = prd;
		e = err;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task automatic do_reset;
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
	endtask
	// watchdog
	initial begin
		repeat (40000) @(posedge clk);
		error_cnt++;
		close_out();
	end
	// main sequence
	initial begin
		do_reset();
		apb(1'b0, A_PFS, 32'h0);
		cmp(rd, 32'h0);
		apb(1'b0, A_TSC, 32'h0);
		cmp(rd, 32'h0);
		cmp(32'(e), 32'h0);
		apb(1'b0, 12'h200, 32'h0);
		cmp(32'(e), 32'h1);
		apb(1'b0, A_ST, 32'h0);
		cmp(rd & 32'h7, 32'h0);
		apb(1'b1, A_PFS, 32'h8);
		@(negedge clk);
		cmp(32'(poe), 32'h1);
		for (int c = 0; c < 4; c++) begin
			apb(1'b1, A_TSC, 32'(c) << 2);
			repeat (3200) @(posedge clk);
			cmp(32'(hi), 32'(1024 >> c));
			cmp(32'(lo), 32'(1024 >> c));
			apb(1'b0, A_ST, 32'h0);
			cmp((rd >> 1) & 32'h3, 32'(c));
		end
		stop <= 1'b1;
		repeat (4) @(posedge clk);
		apb(1'b0, A_ST, 32'h0);
		cmp(rd & 32'h2e, 32'h20);
		stop <= 1'b0;
		// past one boundary the active divisor shows what the field holds
		repeat (1100) @(posedge clk);
		apb(1'b0, A_ST, 32'h0);
		cmp(rd & 32'h6, 32'h0);
		en <= 1'b0;
		repeat (6) @(posedge clk);
		en <= 1'b1;
		apb(1'b1, A_TSC, 32'hc);
		repeat (1100) @(posedge clk);
		apb(1'b0, A_ST, 32'h0);
		cmp((rd >> 1) & 32'h3, 32'h3);
		do_reset();
		repeat (1100) @(posedge clk);
		apb(1'b0, A_ST, 32'h0);
		cmp(rd & 32'h7, 32'h0);
		apb(1'b1, A_PIO, 32'h3);
		@(negedge clk);
		cmp({30'h0, poe, pout}, 32'h3);
		apb(1'b1, A_PIO, 32'h0);
		xen <= 1'b1;
		xv <= 1'b1;
		repeat (4) @(posedge clk);
		apb(1'b0, A_ST, 32'h0);
		cmp({(rd >> 4) & 32'h1}, 32'h1);
		cmp(32'(poe), 32'h0);
		close_out();
	end
endmodule // alarm_tone_output_tb_top
`default_nettype wire
